//--- pkg/fsl_pkg.sv
// Constants and carrier types for the network status lamp driver.
// Assumes a single 25 MHz clock; the phase and flicker times are converted to cycle counts here.
package fsl_pkg;
  localparam int unsigned CLOCK_HZ = 25000000;
  localparam int unsigned PHASE_MS = 200;
  localparam int unsigned FLICKER_MS = 50;
  localparam int unsigned LONG_OFF_MS = 1000;
  localparam int unsigned PHASE_CYC = CLOCK_HZ / 1000 * PHASE_MS;
  localparam int unsigned FLICKER_CYC = CLOCK_HZ / 1000 * FLICKER_MS;
  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned SLOT_W = 3;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h5;
  localparam logic [5:0] SINGLE_PAT = 6'h01;
  localparam logic [5:0] DOUBLE_PAT = 6'h05;
  localparam logic [5:0] BLINK_PAT = 6'h15;

  typedef enum logic [3:0] {
    FSL_INIT = 4'h1,
    FSL_PREOP = 4'h2,
    FSL_SAFEOP = 4'h4,
    FSL_OP = 4'h8
  } fsl_comm_state_t;

  typedef struct packed {
    logic boot_error;
    logic pdi_watchdog;
    logic sm_watchdog;
    logic sync_error;
    logic state_refused;
  } fsl_faults_t;

  typedef struct packed {
    logic [NUM_PORTS-1:0] cable_present;
    logic [NUM_PORTS-1:0] traffic;
    logic controller_running;
  } fsl_ports_t;
endpackage

//--- rtl/fsl_lamp_driver.sv
// Network status lamp driver: state lamp, fault lamp and per-port activity lamps.
// Assumes inputs are synchronous to clock; lamps are active high levels.
`timescale 1ns/10ps
module fsl_lamp_driver
  import fsl_pkg::*;
#(
  parameter int unsigned PHASE_CYCLES = PHASE_CYC,
  parameter int unsigned FLICKER_CYCLES = FLICKER_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire fsl_pkg::fsl_comm_state_t comm_state,
  input wire fsl_pkg::fsl_faults_t faults,
  input wire fsl_pkg::fsl_ports_t ports,
  output logic state_lamp,
  output logic fault_lamp,
  output logic [fsl_pkg::NUM_PORTS-1:0] port_activity_lamp
);
  import fsl_pkg::*;

  // The 1.2 s frame is six 0.2 s slots; patterns pick lit slots.
  typedef struct packed {
    logic [23:0] phase_cnt;
    logic [SLOT_W-1:0] slot;
    logic [23:0] flick_cnt;
    logic flick;
    logic state_lamp;
    logic fault_lamp;
    logic [NUM_PORTS-1:0] port_lamp;
  } fsl_regs_t;

  fsl_regs_t r_q;
  fsl_regs_t r_d;

  function automatic logic pat_on(input logic [5:0] pat, input logic [SLOT_W-1:0] s);
    pat_on = pat[s];
  endfunction

  always_comb begin
    r_d = r_q;
    if (r_q.phase_cnt >= 24'(PHASE_CYCLES - 1)) begin
      r_d.phase_cnt = 24'h000000;
      r_d.slot = (r_q.slot == SLOT_LAST) ? 3'h0 : 3'(r_q.slot + 3'h1);
    end else begin
      r_d.phase_cnt = 24'(r_q.phase_cnt + 24'h000001);
    end
    if (r_q.flick_cnt >= 24'(FLICKER_CYCLES - 1)) begin
      r_d.flick_cnt = 24'h000000;
      r_d.flick = ~r_q.flick;
    end else begin
      r_d.flick_cnt = 24'(r_q.flick_cnt + 24'h000001);
    end
    case (comm_state)
      FSL_INIT: r_d.state_lamp = 1'b0;
      FSL_PREOP: r_d.state_lamp = pat_on(BLINK_PAT, r_q.slot);
      FSL_SAFEOP: r_d.state_lamp = pat_on(SINGLE_PAT, r_q.slot);
      FSL_OP: r_d.state_lamp = 1'b1;
      default: r_d.state_lamp = 1'b0;
    endcase
    // Priority: boot, PDI, SM watchdog, sync, refusal.
    if (faults.boot_error) begin
      r_d.fault_lamp = r_q.flick;
    end else if (faults.pdi_watchdog) begin
      r_d.fault_lamp = 1'b1;
    end else if (faults.sm_watchdog) begin
      r_d.fault_lamp = pat_on(DOUBLE_PAT, r_q.slot);
    end else if (faults.sync_error) begin
      r_d.fault_lamp = pat_on(SINGLE_PAT, r_q.slot);
    end else if (faults.state_refused) begin
      r_d.fault_lamp = pat_on(BLINK_PAT, r_q.slot);
    end else begin
      r_d.fault_lamp = 1'b0;
    end
    for (int i = 0; i < int'(NUM_PORTS); i++) begin
      if (ports.traffic[i]) begin
        r_d.port_lamp[i] = r_q.flick;
      end else if (ports.cable_present[i]) begin
        r_d.port_lamp[i] = 1'b1;
      end else begin
        r_d.port_lamp[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign state_lamp = r_q.state_lamp;
  assign fault_lamp = r_q.fault_lamp;
  assign port_activity_lamp = r_q.port_lamp;

  a_init_dark: assert property (@(posedge clock) disable iff (reset)
    comm_state == FSL_INIT |=> !state_lamp) else $error("state lamp lit in init");
  a_op_lit: assert property (@(posedge clock) disable iff (reset)
    comm_state == FSL_OP |=> state_lamp) else $error("state lamp dark in op");
  a_preop_blink: assert property (@(posedge clock) disable iff (reset)
    comm_state == FSL_PREOP |=> state_lamp == !r_q.slot[0] || r_q.phase_cnt == 24'h0)
    else $error("preop blink wrong");
  a_fault_dark: assert property (@(posedge clock) disable iff (reset)
    faults == '0 |=> !fault_lamp) else $error("fault lamp lit without error");
  a_pdi_steady: assert property (@(posedge clock) disable iff (reset)
    !faults.boot_error && faults.pdi_watchdog |=> fault_lamp) else $error("pdi lamp dark");
  a_boot_flicker: assert property (@(posedge clock) disable iff (reset)
    faults.boot_error |=> fault_lamp == $past(r_q.flick)) else $error("boot flicker wrong");
  a_port_dark: assert property (@(posedge clock) disable iff (reset)
    ports.cable_present == '0 && ports.traffic == '0 |=> port_activity_lamp == '0)
    else $error("port lamp lit without cable");
  a_port_steady: assert property (@(posedge clock) disable iff (reset)
    ports.cable_present[0] && !ports.traffic[0] |=> port_activity_lamp[0])
    else $error("port lamp dark with cable");
  a_refused_blink: assert property (@(posedge clock) disable iff (reset)
    faults == 5'h01 |=> fault_lamp == pat_on(BLINK_PAT, $past(r_q.slot)))
    else $error("refusal blink wrong");

  // State lamp patterns beyond Init and Op.
  // A slot change between sample and check is exempted, as in the blink check above.
  a_safeop_flash: assert property (@(posedge clock) disable iff (reset)
    comm_state == FSL_SAFEOP |=> state_lamp == (r_q.slot == 3'h0) || r_q.phase_cnt == 24'h0)
    else $error("safeop flash wrong");
  a_invalid_dark: assert property (@(posedge clock) disable iff (reset)
    !(comm_state inside {FSL_INIT, FSL_PREOP, FSL_SAFEOP, FSL_OP}) |=> !state_lamp)
    else $error("state lamp lit for bad state code");

  // Fault lamp patterns for the watchdog and sync conditions, and boot error over PDI.
  a_sync_single: assert property (@(posedge clock) disable iff (reset)
    faults == 5'h02 |=> fault_lamp == pat_on(SINGLE_PAT, $past(r_q.slot)))
    else $error("sync flash wrong");
  a_sync_first: assert property (@(posedge clock) disable iff (reset)
    faults == 5'h03 |=> fault_lamp == pat_on(SINGLE_PAT, $past(r_q.slot)))
    else $error("sync does not beat refusal");
  a_sm_double: assert property (@(posedge clock) disable iff (reset)
    !faults.boot_error && !faults.pdi_watchdog && faults.sm_watchdog
    |=> fault_lamp == pat_on(DOUBLE_PAT, $past(r_q.slot)))
    else $error("watchdog double flash wrong");
  a_boot_first: assert property (@(posedge clock) disable iff (reset)
    faults.boot_error && faults.pdi_watchdog |=> fault_lamp == $past(r_q.flick))
    else $error("boot does not beat pdi");

  // Port lamps, checked port by port, then all ports together when idle.
  a_traffic0_flick: assert property (@(posedge clock) disable iff (reset)
    ports.traffic[0] |=> port_activity_lamp[0] == $past(r_q.flick))
    else $error("port0 flicker wrong");
  a_traffic1_flick: assert property (@(posedge clock) disable iff (reset)
    ports.traffic[1] |=> port_activity_lamp[1] == $past(r_q.flick))
    else $error("port1 flicker wrong");
  a_port1_steady: assert property (@(posedge clock) disable iff (reset)
    ports.cable_present[1] && !ports.traffic[1] |=> port_activity_lamp[1])
    else $error("port1 lamp dark with cable");
  a_port0_dark: assert property (@(posedge clock) disable iff (reset)
    !ports.cable_present[0] && !ports.traffic[0] |=> !port_activity_lamp[0])
    else $error("port0 lamp lit without cable");
  a_port1_dark: assert property (@(posedge clock) disable iff (reset)
    !ports.cable_present[1] && !ports.traffic[1] |=> !port_activity_lamp[1])
    else $error("port1 lamp lit without cable");
  // A stopped controller with no cable and no traffic anywhere leaves every port lamp dark.
  a_idle_dark: assert property (@(posedge clock) disable iff (reset)
    !ports.controller_running && ports.cable_present == '0 && ports.traffic == '0
    |=> port_activity_lamp == '0)
    else $error("port lamp lit while idle");

  // Frame timebase: six slots of PHASE_CYCLES, slot 0 first.
  a_slot_range: assert property (@(posedge clock) disable iff (reset)
    r_q.slot <= SLOT_LAST)
    else $error("slot out of frame");
  a_phase_range: assert property (@(posedge clock) disable iff (reset)
    32'(r_q.phase_cnt) < PHASE_CYCLES)
    else $error("phase counter overrun");
  a_slot_step: assert property (@(posedge clock) disable iff (reset)
    r_q.phase_cnt == 24'(PHASE_CYCLES - 1) |=> $changed(r_q.slot))
    else $error("slot did not advance");
  a_slot_hold: assert property (@(posedge clock) disable iff (reset)
    r_q.phase_cnt != 24'(PHASE_CYCLES - 1) |=> $stable(r_q.slot))
    else $error("slot moved early");
  a_frame_wrap: assert property (@(posedge clock) disable iff (reset)
    r_q.slot == SLOT_LAST && r_q.phase_cnt == 24'(PHASE_CYCLES - 1) |=> r_q.slot == 3'h0)
    else $error("frame did not wrap");

  // Flicker timebase: the level toggles once every FLICKER_CYCLES.
  a_flick_range: assert property (@(posedge clock) disable iff (reset)
    32'(r_q.flick_cnt) < FLICKER_CYCLES)
    else $error("flicker counter overrun");
  a_flick_toggle: assert property (@(posedge clock) disable iff (reset)
    r_q.flick_cnt == 24'(FLICKER_CYCLES - 1) |=> $changed(r_q.flick))
    else $error("flicker did not toggle");
  a_flick_hold: assert property (@(posedge clock) disable iff (reset)
    r_q.flick_cnt != 24'(FLICKER_CYCLES - 1) |=> $stable(r_q.flick))
    else $error("flicker toggled early");

  c_preop: cover property (@(posedge clock) comm_state == FSL_PREOP ##1 state_lamp);
  c_boot: cover property (@(posedge clock) faults.boot_error ##1 fault_lamp);
  c_safeop: cover property (@(posedge clock) comm_state == FSL_SAFEOP ##1 state_lamp);
  c_sm_wd: cover property (@(posedge clock) faults.sm_watchdog ##1 fault_lamp);
  c_traffic: cover property (@(posedge clock) ports.traffic[1] ##1 port_activity_lamp[1]);
endmodule

//--- testbench/fsl_lamp_watcher.sv
// Operator model: counts lit cycles of every lamp while watch is high.
// Assumes active high lamps sampled on the rising clock edge.
`timescale 1ns/10ps
module fsl_lamp_watcher (
  input wire logic clock,
  input wire logic watch,
  input wire logic state_lamp,
  input wire logic fault_lamp,
  input wire logic [fsl_pkg::NUM_PORTS-1:0] port_activity_lamp,
  output int state_cnt,
  output int fault_cnt,
  output int port0_cnt,
  output int port1_cnt
);
  // An unknown lamp level is never counted as lit.
  always @(posedge clock) begin
    state_cnt <= watch ? state_cnt + int'(state_lamp === 1'b1) : 0;
    fault_cnt <= watch ? fault_cnt + int'(fault_lamp === 1'b1) : 0;
    port0_cnt <= watch ? port0_cnt + int'(port_activity_lamp[0] === 1'b1) : 0;
    port1_cnt <= watch ? port1_cnt + int'(port_activity_lamp[1] === 1'b1) : 0;
  end
endmodule

//--- testbench/fsl_lamp_driver_tb.sv
// Self-checking bench for the lamp driver with shortened pattern timing.
// Assumes a phase of 10 cycles and a flicker phase of 4 cycles.
`timescale 1ns/10ps
module fsl_lamp_driver_tb;
  import fsl_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic watch = 1'b0;
  fsl_comm_state_t comm_state = FSL_INIT;
  fsl_faults_t faults = '0;
  fsl_ports_t ports = '0;
  logic state_lamp;
  logic fault_lamp;
  logic [NUM_PORTS-1:0] port_activity_lamp;
  int state_cnt, fault_cnt, port0_cnt, port1_cnt;
  int error_cnt = 0;
  int num_checks = 0;
  initial begin
    forever #20 clock = ~clock;
  end
  fsl_lamp_driver #(.PHASE_CYCLES(10), .FLICKER_CYCLES(4)) u_fsl_lamp_driver (
    .clock(clock), .reset(reset), .comm_state(comm_state), .faults(faults),
    .ports(ports), .state_lamp(state_lamp), .fault_lamp(fault_lamp),
    .port_activity_lamp(port_activity_lamp));
  fsl_lamp_watcher u_fsl_lamp_watcher (
    .clock(clock), .watch(watch), .state_lamp(state_lamp), .fault_lamp(fault_lamp),
    .port_activity_lamp(port_activity_lamp), .state_cnt(state_cnt),
    .fault_cnt(fault_cnt), .port0_cnt(port0_cnt), .port1_cnt(port1_cnt));
  task automatic chk(input string what, input int exp, input int seen);
    num_checks++;
    if (exp != seen) begin
      error_cnt++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, seen);
    end
  endtask
  // Watches 120 cycles: two whole frames and fifteen flicker periods.
  task automatic show(input fsl_comm_state_t cs, input fsl_faults_t fl, input fsl_ports_t pt,
      input int s, input int f, input int p0, input int p1);
    @(negedge clock);
    comm_state = cs;
    faults = fl;
    ports = pt;
    repeat (3) @(negedge clock);
    watch = 1'b1;
    repeat (120) @(negedge clock);
    watch = 1'b0;
    chk("state_lamp", s, state_cnt);
    chk("fault_lamp", f, fault_cnt);
    chk("port0_lamp", p0, port0_cnt);
    chk("port1_lamp", p1, port1_cnt);
  endtask
  task automatic scen_idle();
    show(FSL_INIT, 5'h00, 5'h00, 0, 0, 0, 0);
  endtask
  task automatic scen_preop();
    show(FSL_PREOP, 5'h01, 5'h1E, 60, 60, 60, 60);
  endtask
  task automatic scen_safeop();
    show(FSL_SAFEOP, 5'h02, 5'h09, 20, 20, 120, 0);
  endtask
  task automatic scen_op();
    show(FSL_OP, 5'h04, 5'h1C, 120, 40, 120, 60);
  endtask
  task automatic scen_boot();
    show(FSL_OP, 5'h18, 5'h00, 120, 60, 0, 0);
  endtask
  task automatic scen_pdi();
    show(FSL_INIT, 5'h08, 5'h00, 0, 120, 0, 0);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100us;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(negedge clock);
    reset = 1'b0;
    scen_idle();
    scen_preop();
    scen_safeop();
    scen_op();
    scen_boot();
    scen_pdi();
    tally_and_finish();
  end
endmodule
